// [src/exec_map.svh]
// Field positions, widths and cycle counts for the execution unit
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

`define DATA_W 8
`define PROD_W 16
`define PTR_W 16
`define PC_W 24
`define OFS_W 7
`define BIT_SEL_W 3
`define CNT_W 2

`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_H 5

`define SIGN_BIT 7
`define HALF_BIT 3

`define ALL_ONES 8'hFF
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define CYC_THREE 2'h3
`define CYC_CALL 3'h4
`define PC_STEP_ONE 24'h000001
`define PC_STEP_TWO 24'h000002
`define PC_STEP_THREE 24'h000003

`endif

// [src/exec_pkg.sv]
// Types shared by the execution unit and its helpers
package exec_pkg;

   typedef enum logic [4:0] {
      OP_AND_WITH_CONSTANT = 5'h00,
      OP_OR_WITH_CONSTANT = 5'h01,
      OP_SET_MASK_BITS = 5'h02,
      OP_CLEAR_MASK_BITS = 5'h03,
      OP_ZERO_MINUS_TEST = 5'h04,
      OP_MULT_UNSIGNED = 5'h05,
      OP_MULT_SIGNED = 5'h06,
      OP_MULT_SIGNED_BY_UNSIGNED = 5'h07,
      OP_FRAC_MULT_UNSIGNED = 5'h08,
      OP_FRAC_MULT_SIGNED = 5'h09,
      OP_FRAC_MULT_SIGNED_BY_UNSIGNED = 5'h0A,
      OP_POINTER_JUMP = 5'h0B,
      OP_EXTENDED_POINTER_JUMP = 5'h0C,
      OP_POINTER_CALL = 5'h0D,
      OP_EXTENDED_POINTER_CALL = 5'h0E,
      OP_COMPARE_SKIP_EQUAL = 5'h0F,
      OP_COMPARE_IMMEDIATE = 5'h10,
      OP_SKIP_REG_BIT_CLEAR = 5'h11,
      OP_SKIP_REG_BIT_SET = 5'h12,
      OP_SKIP_IO_BIT_CLEAR = 5'h13,
      OP_SKIP_IO_BIT_SET = 5'h14,
      OP_BRANCH_FLAG_SET = 5'h15,
      OP_BRANCH_FLAG_CLEAR = 5'h16
   } op_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } exec_state_t;

endpackage : exec_pkg

// [src/mult_unit.sv]
// Signed, unsigned and mixed 8x8 multiplier with fractional shift
`timescale 1ns/1ps
`include "exec_map.svh"
module mult_unit
   import exec_pkg::*;
(
   // Operands
   input wire logic [`DATA_W-1:0] a,
   input wire logic [`DATA_W-1:0] b,
   // Mode
   input wire logic a_signed,
   input wire logic b_signed,
   input wire logic frac,
   // Result
   output logic [`PROD_W-1:0] product,
   output logic carry,
   output logic zero
);
   logic signed [`DATA_W:0] a_ext;
   logic signed [`DATA_W:0] b_ext;
   logic signed [2*`DATA_W+1:0] full;
   logic [`PROD_W-1:0] raw;

   always_comb
   begin
      a_ext = $signed({a_signed & a[`DATA_W-1], a});
      b_ext = $signed({b_signed & b[`DATA_W-1], b});
      full = a_ext * b_ext;
      raw = full[`PROD_W-1:0];
      // Carry is taken from the top bit before the fractional shift
      carry = raw[`PROD_W-1];
      product = frac ? {raw[`PROD_W-2:0], 1'b0} : raw;
      zero = (product == '0);
   end
endmodule : mult_unit

// [src/cmp_unit.sv]
// Eight-bit compare by subtraction, producing the arithmetic flags
`timescale 1ns/1ps
`include "exec_map.svh"
module cmp_unit
   import exec_pkg::*;
(
   // Operands
   input wire logic [`DATA_W-1:0] minuend,
   input wire logic [`DATA_W-1:0] subtrahend,
   // Flags
   output logic flag_z,
   output logic flag_n,
   output logic flag_v,
   output logic flag_c,
   output logic flag_h
);
   logic [`DATA_W-1:0] d;
   logic [`DATA_W-1:0] k;
   logic [`DATA_W-1:0] r;

   always_comb
   begin
      d = minuend;
      k = subtrahend;
      r = d - k;
      flag_z = (r == '0);
      flag_n = r[`SIGN_BIT];
      flag_v = (d[`SIGN_BIT] & ~k[`SIGN_BIT] & ~r[`SIGN_BIT])
               | (~d[`SIGN_BIT] & k[`SIGN_BIT] & r[`SIGN_BIT]);
      flag_c = (~d[`SIGN_BIT] & k[`SIGN_BIT]) | (k[`SIGN_BIT] & r[`SIGN_BIT])
               | (r[`SIGN_BIT] & ~d[`SIGN_BIT]);
      flag_h = (~d[`HALF_BIT] & k[`HALF_BIT]) | (k[`HALF_BIT] & r[`HALF_BIT])
               | (r[`HALF_BIT] & ~d[`HALF_BIT]);
   end
endmodule : cmp_unit

// [src/cpu_logic_branch_executor.sv]
// Executes logic, multiply, pointer jump and call, skip and branch operations
`timescale 1ns/1ps
`include "exec_map.svh"

module cpu_logic_branch_executor
   import exec_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Issued operation
   input wire logic op_valid,
   input wire op_t op,
   input wire logic [`DATA_W-1:0] dst_val,
   input wire logic [`DATA_W-1:0] src_val,
   input wire logic [`DATA_W-1:0] imm,
   input wire logic [`BIT_SEL_W-1:0] bit_sel,
   input wire logic [`OFS_W-1:0] branch_ofs,
   input wire logic [`DATA_W-1:0] io_val,
   input wire logic next_two_word,
   // Architectural state in
   input wire logic [`DATA_W-1:0] status_flags_in,
   input wire logic [`PTR_W-1:0] z_ptr,
   input wire logic [`DATA_W-1:0] extended_indirect_high,
   input wire logic [`PC_W-1:0] pc_in,
   // Handshake
   output logic ready_q,
   output logic done_q,
   // Register writeback
   output logic wr_en_q,
   output logic [`DATA_W-1:0] wr_data_q,
   output logic prod_en_q,
   output logic [`PROD_W-1:0] prod_data_q,
   // Status writeback
   output logic status_en_q,
   output logic [`DATA_W-1:0] status_flags_q,
   // Program counter and stack
   output logic pc_load_q,
   output logic [`PC_W-1:0] pc_out_q,
   output logic push_en_q,
   output logic [`PC_W-1:0] push_addr_q
);

   // Helpers
   logic [`PROD_W-1:0] m_prod;
   logic m_carry;
   logic m_zero;
   logic m_a_signed;
   logic m_b_signed;
   logic m_frac;
   logic c_z;
   logic c_n;
   logic c_v;
   logic c_c;
   logic c_h;

   mult_unit u_mult (
      .a(dst_val),
      .b(src_val),
      .a_signed(m_a_signed),
      .b_signed(m_b_signed),
      .frac(m_frac),
      .product(m_prod),
      .carry(m_carry),
      .zero(m_zero)
   );

   cmp_unit u_cmp (
      .minuend(dst_val),
      .subtrahend(imm),
      .flag_z(c_z),
      .flag_n(c_n),
      .flag_v(c_v),
      .flag_c(c_c),
      .flag_h(c_h)
   );

   // Logic results put Z N V; V always clears for these operations
   function automatic logic [`DATA_W-1:0] logic_flags(
      input logic [`DATA_W-1:0] status_flags_register,
      input logic [`DATA_W-1:0] res
   );
      logic [`DATA_W-1:0] f;
      f = status_flags_register;
      f[`FLAG_Z] = (res == '0);
      f[`FLAG_N] = res[`DATA_W-1];
      f[`FLAG_V] = 1'b0;
      return f;
   endfunction : logic_flags

   // Skip distance and cycle count depend on the following word count
   function automatic logic [`CNT_W-1:0] skip_cycles(input logic take, input logic two);
      logic [`CNT_W-1:0] c;
      c = `CYC_ONE;
      if (take)
         c = two ? `CYC_THREE : `CYC_TWO;
      return c;
   endfunction : skip_cycles

   function automatic logic [`PC_W-1:0] skip_target(
      input logic [`PC_W-1:0] pc,
      input logic take,
      input logic two
   );
      logic [`PC_W-1:0] t;
      t = pc + `PC_STEP_ONE;
      if (take)
         t = pc + (two ? `PC_STEP_THREE : `PC_STEP_TWO);
      return t;
   endfunction : skip_target

   // Control state
   exec_state_t state_q, state_d;
   logic [2:0] cnt_q, cnt_d;
   logic ready_d;
   logic done_d;
   logic wr_en_d;
   logic prod_en_d;
   logic status_en_d;
   logic pc_load_d;
   logic push_en_d;
   logic [`DATA_W-1:0] wr_data_d;
   logic [`PROD_W-1:0] prod_data_d;
   logic [`DATA_W-1:0] status_flags_d;
   logic [`PC_W-1:0] pc_out_d;
   logic [`PC_W-1:0] push_addr_d;
   // Strobes held while a multi-cycle operation waits
   logic [4:0] pend_q, pend_d;

   logic accept;
   logic [2:0] cyc;
   logic [4:0] fresh;
   logic take;
   logic reg_bit;
   logic io_bit;
   logic status_flags_register_bit;
   logic [`PC_W-1:0] seq_pc;
   logic [`PC_W-1:0] z_target;
   logic [`PC_W-1:0] ez_target;
   logic [`PC_W-1:0] br_target;
   logic [`DATA_W-1:0] lres;

   always_comb
   begin
      accept = op_valid && (state_q == ST_IDLE);
      reg_bit = dst_val[bit_sel];
      io_bit = io_val[bit_sel];
      status_flags_register_bit = status_flags_in[bit_sel];
      seq_pc = pc_in + `PC_STEP_ONE;
      z_target = {{(`PC_W-`PTR_W){1'b0}}, z_ptr};
      ez_target = {extended_indirect_high, z_ptr};
      br_target = pc_in + {{(`PC_W-`OFS_W){branch_ofs[`OFS_W-1]}}, branch_ofs}
                  + `PC_STEP_ONE;
      m_a_signed = (op == OP_MULT_SIGNED) || (op == OP_FRAC_MULT_SIGNED)
                   || (op == OP_MULT_SIGNED_BY_UNSIGNED)
                   || (op == OP_FRAC_MULT_SIGNED_BY_UNSIGNED);
      m_b_signed = (op == OP_MULT_SIGNED) || (op == OP_FRAC_MULT_SIGNED);
      m_frac = (op == OP_FRAC_MULT_UNSIGNED) || (op == OP_FRAC_MULT_SIGNED)
               || (op == OP_FRAC_MULT_SIGNED_BY_UNSIGNED);

      // Defaults: hold data outputs, drop strobes
      state_d = state_q;
      cnt_d = cnt_q;
      pend_d = pend_q;
      ready_d = ready_q;
      done_d = 1'b0;
      wr_en_d = 1'b0;
      prod_en_d = 1'b0;
      status_en_d = 1'b0;
      pc_load_d = 1'b0;
      push_en_d = 1'b0;
      wr_data_d = wr_data_q;
      prod_data_d = prod_data_q;
      status_flags_d = status_flags_q;
      pc_out_d = pc_out_q;
      push_addr_d = push_addr_q;
      cyc = {1'b0, `CYC_ONE};
      fresh = '0;
      take = 1'b0;
      lres = dst_val;

      if (accept)
      begin
         // Fresh strobe order: wr, prod, status, pc, push
         pc_out_d = seq_pc;
         unique case (op)
            OP_AND_WITH_CONSTANT,
            OP_OR_WITH_CONSTANT,
            OP_SET_MASK_BITS,
            OP_CLEAR_MASK_BITS,
            OP_ZERO_MINUS_TEST:
            begin
               unique case (op)
                  OP_AND_WITH_CONSTANT: lres = dst_val & imm;
                  OP_OR_WITH_CONSTANT: lres = dst_val | imm;
                  OP_SET_MASK_BITS: lres = dst_val | imm;
                  OP_CLEAR_MASK_BITS: lres = dst_val & (`ALL_ONES - imm);
                  default: lres = dst_val & dst_val;
               endcase
               wr_data_d = lres;
               status_flags_d = logic_flags(status_flags_in, lres);
               fresh = 5'b10110;
               cyc = {1'b0, `CYC_ONE};
            end
            OP_MULT_UNSIGNED,
            OP_MULT_SIGNED,
            OP_MULT_SIGNED_BY_UNSIGNED,
            OP_FRAC_MULT_UNSIGNED,
            OP_FRAC_MULT_SIGNED,
            OP_FRAC_MULT_SIGNED_BY_UNSIGNED:
            begin
               prod_data_d = m_prod;
               status_flags_d = status_flags_in;
               status_flags_d[`FLAG_Z] = m_zero;
               status_flags_d[`FLAG_C] = m_carry;
               fresh = 5'b01110;
               cyc = {1'b0, `CYC_TWO};
            end
            OP_POINTER_JUMP,
            OP_EXTENDED_POINTER_JUMP:
            begin
               pc_out_d = (op == OP_POINTER_JUMP) ? z_target : ez_target;
               fresh = 5'b00010;
               cyc = {1'b0, `CYC_TWO};
            end
            OP_POINTER_CALL,
            OP_EXTENDED_POINTER_CALL:
            begin
               pc_out_d = (op == OP_POINTER_CALL) ? z_target : ez_target;
               push_addr_d = seq_pc;
               fresh = 5'b00011;
               cyc = `CYC_CALL;
            end
            OP_COMPARE_IMMEDIATE:
            begin
               status_flags_d = status_flags_in;
               status_flags_d[`FLAG_Z] = c_z;
               status_flags_d[`FLAG_N] = c_n;
               status_flags_d[`FLAG_V] = c_v;
               status_flags_d[`FLAG_C] = c_c;
               status_flags_d[`FLAG_H] = c_h;
               fresh = 5'b00110;
               cyc = {1'b0, `CYC_ONE};
            end
            OP_COMPARE_SKIP_EQUAL,
            OP_SKIP_REG_BIT_CLEAR,
            OP_SKIP_REG_BIT_SET,
            OP_SKIP_IO_BIT_CLEAR,
            OP_SKIP_IO_BIT_SET:
            begin
               unique case (op)
                  OP_COMPARE_SKIP_EQUAL: take = (dst_val == src_val);
                  OP_SKIP_REG_BIT_CLEAR: take = ~reg_bit;
                  OP_SKIP_REG_BIT_SET: take = reg_bit;
                  OP_SKIP_IO_BIT_CLEAR: take = ~io_bit;
                  default: take = io_bit;
               endcase
               pc_out_d = skip_target(pc_in, take, next_two_word);
               cyc = {1'b0, skip_cycles(take, next_two_word)};
               fresh = 5'b00010;
            end
            OP_BRANCH_FLAG_SET,
            OP_BRANCH_FLAG_CLEAR:
            begin
               take = (op == OP_BRANCH_FLAG_SET) ? status_flags_register_bit : ~status_flags_register_bit;
               pc_out_d = take ? br_target : seq_pc;
               cyc = take ? {1'b0, `CYC_TWO} : {1'b0, `CYC_ONE};
               fresh = 5'b00010;
            end
            default:
            begin
               // Unknown codes retire as a one-cycle no-operation
               fresh = 5'b00010;
               cyc = {1'b0, `CYC_ONE};
            end
         endcase
         if (cyc == {1'b0, `CYC_ONE})
         begin
            {wr_en_d, prod_en_d, status_en_d, pc_load_d, push_en_d} = fresh;
            done_d = 1'b1;
         end
         else
         begin
            // Results are held so operands may change while waiting
            pend_d = fresh;
            cnt_d = cyc - 3'h1;
            ready_d = 1'b0;
            state_d = ST_WAIT;
         end
      end
      else if (state_q == ST_WAIT)
      begin
         cnt_d = cnt_q - 3'h1;
         if (cnt_q == 3'h1)
         begin
            {wr_en_d, prod_en_d, status_en_d, pc_load_d, push_en_d} = pend_q;
            done_d = 1'b1;
            ready_d = 1'b1;
            pend_d = '0;
            state_d = ST_IDLE;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         pend_q <= '0;
         ready_q <= 1'b1;
         done_q <= 1'b0;
         wr_en_q <= 1'b0;
         prod_en_q <= 1'b0;
         status_en_q <= 1'b0;
         pc_load_q <= 1'b0;
         push_en_q <= 1'b0;
         wr_data_q <= '0;
         prod_data_q <= '0;
         status_flags_q <= '0;
         pc_out_q <= '0;
         push_addr_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         pend_q <= pend_d;
         ready_q <= ready_d;
         done_q <= done_d;
         wr_en_q <= wr_en_d;
         prod_en_q <= prod_en_d;
         status_en_q <= status_en_d;
         pc_load_q <= pc_load_d;
         push_en_q <= push_en_d;
         wr_data_q <= wr_data_d;
         prod_data_q <= prod_data_d;
         status_flags_q <= status_flags_d;
         pc_out_q <= pc_out_d;
         push_addr_q <= push_addr_d;
      end
   end

endmodule : cpu_logic_branch_executor

// [test/cpu_logic_branch_executor_chk.sv]
// Assertion checker for the execution unit ports
`timescale 1ns/1ps
`include "exec_map.svh"
module cpu_logic_branch_executor_chk
   import exec_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Issue side
   input wire logic op_valid,
   input wire op_t op,
   input wire logic [`DATA_W-1:0] dst_val,
   input wire logic [`DATA_W-1:0] imm,
   input wire logic [`BIT_SEL_W-1:0] bit_sel,
   input wire logic [`OFS_W-1:0] branch_ofs,
   input wire logic [`DATA_W-1:0] status_flags_in,
   input wire logic [`PTR_W-1:0] z_ptr,
   input wire logic [`DATA_W-1:0] extended_indirect_high,
   input wire logic [`PC_W-1:0] pc_in,
   // Results
   input wire logic ready_q,
   input wire logic done_q,
   input wire logic wr_en_q,
   input wire logic [`DATA_W-1:0] wr_data_q,
   input wire logic prod_en_q,
   input wire logic status_en_q,
   input wire logic pc_load_q,
   input wire logic [`PC_W-1:0] pc_out_q,
   input wire logic push_en_q,
   input wire logic [`PC_W-1:0] push_addr_q
);
   // An offer only counts while the unit is idle
   logic take;
   logic flow_op;
   logic [`PC_W-1:0] br_tgt;
   assign take = op_valid && ready_q;
   assign flow_op = op inside {OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR,
      OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
      OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR};
   assign br_tgt = pc_in + {{17{branch_ofs[6]}}, branch_ofs} + `PC_STEP_ONE;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence mult_wait;
      !done_q ##1 done_q && prod_en_q;
   endsequence
   sequence call_wait;
      !done_q [*3] ##1 done_q && push_en_q;
   endsequence

   logic_retire_a:
      assert property (take && op inside {OP_AND_WITH_CONSTANT, OP_OR_WITH_CONSTANT,
         OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_ZERO_MINUS_TEST}
         |=> done_q && wr_en_q && status_en_q) else $error("logic op not retired");
   and_result_a:
      assert property (take && op == OP_AND_WITH_CONSTANT
         |=> wr_data_q == ($past(dst_val) & $past(imm))) else $error("and result");
   or_result_a:
      assert property (take && op inside {OP_OR_WITH_CONSTANT, OP_SET_MASK_BITS}
         |=> wr_data_q == ($past(dst_val) | $past(imm))) else $error("or result");
   clear_result_a:
      assert property (take && op == OP_CLEAR_MASK_BITS
         |=> wr_data_q == ($past(dst_val) & (`ALL_ONES - $past(imm))))
      else $error("clear result");
   mult_timing_a:
      assert property (take && op inside {[OP_MULT_UNSIGNED:OP_FRAC_MULT_SIGNED_BY_UNSIGNED]}
         |=> mult_wait) else $error("product not written in two cycles");
   jump_target_a:
      assert property (take && op == OP_POINTER_JUMP
         |=> !done_q ##1 pc_load_q && pc_out_q == {8'h00, $past(z_ptr, 2)})
      else $error("pointer jump target");
   ext_jump_a:
      assert property (take && op == OP_EXTENDED_POINTER_JUMP |=> !done_q ##1 pc_load_q
         && pc_out_q == {$past(extended_indirect_high, 2), $past(z_ptr, 2)})
      else $error("extended jump target");
   call_push_a:
      assert property (take && op inside {OP_POINTER_CALL, OP_EXTENDED_POINTER_CALL}
         |=> call_wait ##0 push_addr_q == $past(pc_in, 4) + `PC_STEP_ONE)
      else $error("call push or timing");
   branch_taken_a:
      assert property (take && op == OP_BRANCH_FLAG_SET && status_flags_in[bit_sel]
         |=> !done_q ##1 done_q && pc_out_q == $past(br_tgt, 2))
      else $error("taken branch target");
   skip_flags_a:
      assert property (take && flow_op |-> ##[1:3] (done_q && !status_en_q))
      else $error("skip or branch touched flags");
endmodule : cpu_logic_branch_executor_chk

bind cpu_logic_branch_executor cpu_logic_branch_executor_chk u_chk (.clk, .rst_b,
   .op_valid, .op, .dst_val, .imm, .bit_sel, .branch_ofs, .status_flags_in, .z_ptr,
   .extended_indirect_high, .pc_in, .ready_q, .done_q, .wr_en_q, .wr_data_q, .prod_en_q,
   .status_en_q, .pc_load_q, .pc_out_q, .push_en_q, .push_addr_q);

// [test/cpu_logic_branch_executor_bench.sv]
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`include "exec_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
$display("Error %s expected %h seen %h", nm, e, g); end end
module cpu_logic_branch_executor_bench
   import exec_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic op_valid = 1'b0;
   op_t op = OP_AND_WITH_CONSTANT;
   logic [7:0] dst_val = 8'h00, src_val = 8'h00, imm = 8'h00, io_val = 8'h00;
   logic [2:0] bit_sel = 3'h0;
   logic [6:0] branch_ofs = 7'h00;
   logic next_two_word = 1'b0;
   logic [7:0] status_flags_in = 8'h00, extended_indirect_high = 8'h00;
   logic [15:0] z_ptr = 16'h0000;
   logic [23:0] pc_in = 24'h000000;
   logic ready_q, done_q, wr_en_q, prod_en_q, status_en_q, pc_load_q, push_en_q;
   logic [7:0] wr_data_q, status_flags_q;
   logic [15:0] prod_data_q;
   logic [23:0] pc_out_q, push_addr_q;
   int num_errors = 0;
   int n_checks = 0;
   op_t sk[5] = '{OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
      OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET};

   always #2.5 clk = ~clk;

   cpu_logic_branch_executor u_cpu_logic_branch_executor (.clk, .rst_b, .op_valid, .op,
      .dst_val, .src_val, .imm, .bit_sel, .branch_ofs, .io_val, .next_two_word,
      .status_flags_in, .z_ptr, .extended_indirect_high, .pc_in, .ready_q, .done_q,
      .wr_en_q, .wr_data_q, .prod_en_q, .prod_data_q, .status_en_q, .status_flags_q,
      .pc_load_q, .pc_out_q, .push_en_q, .push_addr_q);

   task automatic results();
      if (num_errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results

   // Idle edge first, so a lowered valid is never raised in the same step
   task automatic run(input op_t o, input int n);
      int c;
      @(posedge clk);
      #1 op = o;
      op_valid = 1'b1;
      @(posedge clk);
      #1 op_valid = 1'b0;
      if (n > 1)
         `CHK("busy", 1'b0, ready_q)
      c = 1;
      while (done_q !== 1'b1 && c < 8)
      begin
         @(posedge clk);
         #1 c++;
      end
      `CHK("cycles", n, c)
      `CHK("pc_load", 1'b1, pc_load_q)
   endtask : run

   task automatic t_logic(input op_t o, input logic [7:0] d, k, r);
      dst_val = d;
      imm = k;
      status_flags_in = 8'hFF;
      run(o, 1);
      `CHK("wr_data", r, wr_data_q)
      `CHK("wr_en", 1'b1, wr_en_q)
      `CHK("status_en", 1'b1, status_en_q)
      `CHK("flags", {4'hF, 1'b0, r[7], r == 8'h00, 1'b1}, status_flags_q)
   endtask : t_logic

   task automatic t_cmp(input logic [7:0] d, k, f);
      dst_val = d;
      imm = k;
      status_flags_in = 8'h50;
      run(OP_COMPARE_IMMEDIATE, 1);
      `CHK("no_store", 1'b0, wr_en_q)
      `CHK("status_en", 1'b1, status_en_q)
      `CHK("flags", f, status_flags_q)
   endtask : t_cmp

   task automatic t_mult(input op_t o, input logic [7:0] a, b, input logic [15:0] p,
      input logic c);
      dst_val = a;
      src_val = b;
      status_flags_in = 8'hFC;
      run(o, 2);
      `CHK("product", p, prod_data_q)
      `CHK("prod_en", 1'b1, prod_en_q)
      `CHK("wr_en", 1'b0, wr_en_q)
      `CHK("flags", {6'h3F, p == 16'h0000, c}, status_flags_q)
   endtask : t_mult

   task automatic t_flow(input op_t o, input int n, input logic [23:0] t);
      z_ptr = 16'hBEEF;
      extended_indirect_high = 8'h01;
      pc_in = 24'h000200;
      run(o, n);
      `CHK("pc_out", t, pc_out_q)
      `CHK("push", n == 4, push_en_q)
      `CHK("status_en", 1'b0, status_en_q)
      if (n == 4)
         `CHK("ret_addr", 24'h000201, push_addr_q)
   endtask : t_flow

   task automatic t_skip(input op_t o, input logic tk, two);
      logic bv;
      logic io;
      logic [7:0] v;
      bv = (o == OP_SKIP_REG_BIT_CLEAR || o == OP_SKIP_IO_BIT_CLEAR) ? !tk : tk;
      io = o inside {OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET};
      v = bv ? 8'h10 : 8'hEF;
      bit_sel = 3'h4;
      dst_val = io ? ~v : v;
      io_val = io ? v : ~v;
      src_val = tk ? v : ~v;
      next_two_word = two;
      pc_in = 24'h000300;
      run(o, tk ? 2 + two : 1);
      `CHK("pc_out", pc_in + (tk ? 24'h2 + two : 24'h1), pc_out_q)
      `CHK("status_en", 1'b0, status_en_q)
   endtask : t_skip

   task automatic t_branch(input op_t o, input logic [2:0] b);
      logic tk;
      logic [23:0] e;
      status_flags_in = 8'hA5;
      bit_sel = b;
      branch_ofs = b[0] ? 7'h40 : 7'h3F;
      pc_in = 24'h001000;
      tk = (o == OP_BRANCH_FLAG_SET) == status_flags_in[b];
      e = tk ? pc_in + {{17{branch_ofs[6]}}, branch_ofs} + 24'h1 : pc_in + 24'h1;
      run(o, tk ? 2 : 1);
      `CHK("pc_out", e, pc_out_q)
      `CHK("status_en", 1'b0, status_en_q)
   endtask : t_branch

   // Reset in mid-call must drop the pending retirement
   task automatic t_reset();
      `CHK("ready", 1'b1, ready_q)
      `CHK("pc_out", 24'h000000, pc_out_q)
      @(posedge clk);
      #1 op = OP_POINTER_CALL;
      op_valid = 1'b1;
      @(posedge clk);
      #1 op_valid = 1'b0;
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_b = 1'b1;
      `CHK("ready", 1'b1, ready_q)
      // Watch every edge where the dropped call would have retired
      repeat (4)
      begin
         @(posedge clk);
         #1 `CHK("push", 1'b0, push_en_q)
      end
   endtask : t_reset

   initial
   begin
      repeat (12) @(posedge clk);
      #1 rst_b = 1'b1;
      t_reset();
      t_logic(OP_AND_WITH_CONSTANT, 8'hF0, 8'h0F, 8'h00);
      t_logic(OP_AND_WITH_CONSTANT, 8'hC3, 8'hF0, 8'hC0);
      t_logic(OP_OR_WITH_CONSTANT, 8'h01, 8'h02, 8'h03);
      t_logic(OP_SET_MASK_BITS, 8'h00, 8'h00, 8'h00);
      t_logic(OP_SET_MASK_BITS, 8'h40, 8'h81, 8'hC1);
      t_logic(OP_CLEAR_MASK_BITS, 8'hFF, 8'h7F, 8'h80);
      t_logic(OP_ZERO_MINUS_TEST, 8'hA5, 8'h00, 8'hA5);
      t_logic(OP_ZERO_MINUS_TEST, 8'h00, 8'hFF, 8'h00);
      t_cmp(8'h10, 8'h01, 8'h70);
      t_cmp(8'h00, 8'h01, 8'h75);
      t_cmp(8'h80, 8'h01, 8'h78);
      t_cmp(8'h05, 8'h05, 8'h52);
      t_mult(OP_MULT_UNSIGNED, 8'hFF, 8'h80, 16'h7F80, 1'b0);
      t_mult(OP_MULT_UNSIGNED, 8'h00, 8'h80, 16'h0000, 1'b0);
      t_mult(OP_MULT_SIGNED, 8'hFF, 8'h80, 16'h0080, 1'b0);
      t_mult(OP_MULT_SIGNED_BY_UNSIGNED, 8'hFF, 8'h80, 16'hFF80, 1'b1);
      t_mult(OP_FRAC_MULT_UNSIGNED, 8'hFF, 8'h80, 16'hFF00, 1'b0);
      t_mult(OP_FRAC_MULT_SIGNED, 8'hFF, 8'h80, 16'h0100, 1'b0);
      t_mult(OP_FRAC_MULT_SIGNED_BY_UNSIGNED, 8'hFF, 8'h80, 16'hFF00, 1'b1);
      t_flow(OP_POINTER_JUMP, 2, 24'h00BEEF);
      t_flow(OP_EXTENDED_POINTER_JUMP, 2, 24'h01BEEF);
      t_flow(OP_POINTER_CALL, 4, 24'h00BEEF);
      t_flow(OP_EXTENDED_POINTER_CALL, 4, 24'h01BEEF);
      foreach (sk[i]) for (int t = 0; t < 4; t++) t_skip(sk[i], t[1], t[0]);
      for (int b = 0; b < 16; b++) t_branch(b[3] ? OP_BRANCH_FLAG_CLEAR : OP_BRANCH_FLAG_SET,
         b[2:0]);
      results();
   end

   // About 176 cycles of work; 3000 cycles, some seventeen times that, is surely a hang
   initial
   begin
      #15000;
      num_errors++;
      results();
   end
endmodule : cpu_logic_branch_executor_bench
